/* src/wmx_pkg.sv */
package wmx_pkg;
  // ----------------------------------------
  // Operation select codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    WMX_OP_MIN_TO_MEM,
    WMX_OP_MUL_U,
    WMX_OP_MUL_S,
    WMX_OP_XOR_A,
    WMX_OP_XOR_B,
    WMX_OP_TBL
  } wmx_op_e;

  // ----------------------------------------
  // Condition flag bit positions
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_I = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_X = 6;
  localparam int FLAG_S = 7;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int PROD_W = 32;
  localparam int FRAC_W = 24;
  localparam int TBL_STEP = 2;
  localparam logic [7:0] FLAGS_RST = 8'hD0;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------
  // Cycle counts (in core_clk cycles)
  // ----------------------------------------
  localparam logic [1:0] MUL_CYC = 2'h1;
  localparam logic [1:0] MULS_CYC_OLD = 2'h1;
  localparam logic [1:0] MULS_CYC_NEW = 2'h2;
endpackage

/* src/wmx_subflags.sv */
`timescale 1ns/1ns
// Sixteen-bit subtract with borrow-style flags
module wmx_subflags (
  // Operands
  input wire logic [wmx_pkg::WORD_W-1:0] minuend,
  input wire logic [wmx_pkg::WORD_W-1:0] subtrahend,
  // Results
  output logic [wmx_pkg::WORD_W-1:0] diff,
  output logic negFlag,
  output logic zeroFlag,
  output logic ovfFlag,
  output logic borrowFlag
);
  import wmx_pkg::*;

  logic d15;
  logic m15;
  logic r15;

  // Difference and its sign bits
  always_comb begin
    diff = minuend - subtrahend;
    d15 = minuend[WORD_W-1];
    m15 = subtrahend[WORD_W-1];
    r15 = diff[WORD_W-1];
  end

  // Flag equations
  always_comb begin
    negFlag = r15; // [RQ2]
    zeroFlag = (diff == WORD_RST); // [RQ2]
    ovfFlag = (d15 & ~m15 & ~r15) | (~d15 & m15 & r15); // [RQ3]
    borrowFlag = (~d15 & m15) | (m15 & r15) | (r15 & ~d15); // [RQ4]
  end
endmodule // wmx_subflags

/* src/wmx_interp.sv */
`timescale 1ns/1ns
// Table interpolation arithmetic
module wmx_interp (
  // Operands
  input wire logic [wmx_pkg::WORD_W-1:0] lowEntry,
  input wire logic [wmx_pkg::WORD_W-1:0] highEntry,
  input wire logic [wmx_pkg::BYTE_W-1:0] fraction,
  // Results
  output logic [wmx_pkg::WORD_W-1:0] result,
  output logic roundUp
);
  import wmx_pkg::*;

  logic signed [WORD_W:0] delta;
  logic signed [FRAC_W:0] scaled;
  logic signed [FRAC_W:0] sum;

  // Signed step times unsigned fraction, radix between bits 7 and 8
  always_comb begin
    delta = $signed({1'b0, highEntry}) - $signed({1'b0, lowEntry});
    scaled = (FRAC_W+1)'(delta) * (FRAC_W+1)'($signed({1'b0, fraction})); // [RQ15]
    sum = $signed({1'b0, lowEntry, 8'h00}) + scaled;
    result = sum[FRAC_W-1:BYTE_W]; // [RQ13]
    roundUp = sum[BYTE_W-1]; // [RQ17]
  end
endmodule // wmx_interp

/* src/wmx_datapath.sv */
`timescale 1ns/1ns
//
// Behaviour
// [RQ1] Store-minimum writes smaller of D and memory
// [RQ2] Store-minimum N, Z from D minus memory
// [RQ3] Store-minimum V is subtraction overflow
// [RQ4] Store-minimum C is subtraction borrow
// [RQ5] Unsigned multiply D by Y into Y:D
// [RQ6] Signed multiply D by Y into Y:D
// [RQ7] Multiply N bit 31, Z whole product, V kept
// [RQ8] Multiply C loaded with product bit 15
// [RQ9] Newer core signed multiply extra cycle before prefix
// [RQ10] First-accumulator XOR writes result into A
// [RQ11] Second-accumulator XOR writes result into B
// [RQ12] XOR N bit 7, Z zero, V cleared
// [RQ13] Interpolate Y1 plus B times difference into D
// [RQ14] Software loads fraction in B, points index
// [RQ15] Product formed as 24-bit with radix 7/8
// [RQ16] Interpolate first entry by plain indexed only
// [RQ17] Interpolate N, Z from result, C round-up
// [RQ18] Unlisted flags keep previous values
// [RQ19] XOR leaves carry unchanged
module wmx_datapath (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request from sequencer
  input wire logic opStart,
  input wire wmx_pkg::wmx_op_e opSel,
  input wire logic newerCore,
  input wire logic nextIsPrefixed,
  // Register file inputs
  input wire logic [wmx_pkg::WORD_W-1:0] accD,
  input wire logic [wmx_pkg::WORD_W-1:0] idxY,
  input wire logic [wmx_pkg::BYTE_W-1:0] flagsIn,
  // Memory operands
  input wire logic [wmx_pkg::WORD_W-1:0] memWord,
  input wire logic [wmx_pkg::WORD_W-1:0] memWordNext,
  input wire logic [wmx_pkg::BYTE_W-1:0] memByte,
  // Results
  output logic done,
  output logic busy,
  output logic [wmx_pkg::WORD_W-1:0] resD,
  output logic resDWe,
  output logic [wmx_pkg::WORD_W-1:0] resY,
  output logic resYWe,
  output logic [wmx_pkg::BYTE_W-1:0] resA,
  output logic resAWe,
  output logic [wmx_pkg::BYTE_W-1:0] resB,
  output logic resBWe,
  output logic [wmx_pkg::WORD_W-1:0] memWrData,
  output logic memWe,
  output logic [wmx_pkg::BYTE_W-1:0] flagsOut
);
  import wmx_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    WMX_IDLE,
    WMX_WAIT
  } wmx_state_e;

  typedef struct packed {
    wmx_state_e state;
    logic [1:0] waitCnt;
    logic busy;
    logic done;
    logic [WORD_W-1:0] resD;
    logic resDWe;
    logic [WORD_W-1:0] resY;
    logic resYWe;
    logic [BYTE_W-1:0] resA;
    logic resAWe;
    logic [BYTE_W-1:0] resB;
    logic resBWe;
    logic [WORD_W-1:0] memWrData;
    logic memWe;
    logic [BYTE_W-1:0] flags;
  } wmx_state_s;

  wmx_state_s st_q;
  wmx_state_s st_d;

  // ----------------------------------------
  // Arithmetic units
  // ----------------------------------------
  logic subN;
  logic subZ;
  logic subV;
  logic subC;
  logic [WORD_W-1:0] tblRes;
  logic tblRound;
  logic [PROD_W-1:0] prodU;
  logic [PROD_W-1:0] prodS;
  logic [PROD_W-1:0] prod;
  logic [BYTE_W-1:0] xorRes;

  // Internal subtraction D minus memory word
  wmx_subflags u_sub (
    .minuend(accD),
    .subtrahend(memWord),
    .diff(),
    .negFlag(subN),
    .zeroFlag(subZ),
    .ovfFlag(subV),
    .borrowFlag(subC)
  );

  // Interpolation between two table entries
  wmx_interp u_interp (
    .lowEntry(memWord),
    .highEntry(memWordNext),
    .fraction(accD[BYTE_W-1:0]), // [RQ14]
    .result(tblRes),
    .roundUp(tblRound)
  );

  // Products and the XOR byte
  always_comb begin
    prodU = PROD_W'(accD) * PROD_W'(idxY); // [RQ5]
    prodS = PROD_W'($signed(accD)) * PROD_W'($signed(idxY)); // [RQ6]
    prod = (opSel == WMX_OP_MUL_S) ? prodS : prodU;
    xorRes = ((opSel == WMX_OP_XOR_A) ? accD[WORD_W-1:BYTE_W] : accD[BYTE_W-1:0])
      ^ memByte; // [RQ10] [RQ11]
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.resDWe = 1'b0;
    st_d.resYWe = 1'b0;
    st_d.resAWe = 1'b0;
    st_d.resBWe = 1'b0;
    st_d.memWe = 1'b0;
    unique case (st_q.state)
      WMX_IDLE: begin
        if (opStart) begin
          // Start from caller's flags so unlisted bits survive
          st_d.flags = flagsIn; // [RQ18]
          unique case (opSel)
            WMX_OP_MIN_TO_MEM: begin
              st_d.memWrData = subC ? accD : memWord; // [RQ1]
              st_d.memWe = 1'b1;
              st_d.flags[FLAG_N] = subN; // [RQ2]
              st_d.flags[FLAG_Z] = subZ; // [RQ2]
              st_d.flags[FLAG_V] = subV; // [RQ3]
              st_d.flags[FLAG_C] = subC; // [RQ4]
              st_d.done = 1'b1;
            end
            WMX_OP_MUL_U, WMX_OP_MUL_S: begin
              st_d.resY = prod[PROD_W-1:WORD_W]; // [RQ5] [RQ6]
              st_d.resD = prod[WORD_W-1:0];
              st_d.flags[FLAG_N] = prod[PROD_W-1]; // [RQ7]
              st_d.flags[FLAG_Z] = (prod == 32'h00000000); // [RQ7]
              st_d.flags[FLAG_C] = prod[WORD_W-1]; // [RQ8]
              // Extra free cycle for signed multiply only, on newer core before a prefixed opcode
              if (opSel == WMX_OP_MUL_S && newerCore && nextIsPrefixed) begin
                st_d.waitCnt = MULS_CYC_NEW; // [RQ9]
              end else begin
                st_d.waitCnt = MUL_CYC;
              end
              st_d.busy = 1'b1;
              st_d.state = WMX_WAIT;
            end
            WMX_OP_XOR_A: begin
              st_d.resA = xorRes; // [RQ10]
              st_d.resAWe = 1'b1;
              st_d.flags[FLAG_N] = xorRes[BYTE_W-1]; // [RQ12]
              st_d.flags[FLAG_Z] = (xorRes == BYTE_RST); // [RQ12]
              st_d.flags[FLAG_V] = 1'b0; // [RQ12]
              st_d.done = 1'b1; // [RQ19]
            end
            WMX_OP_XOR_B: begin
              st_d.resB = xorRes; // [RQ11]
              st_d.resBWe = 1'b1;
              st_d.flags[FLAG_N] = xorRes[BYTE_W-1]; // [RQ12]
              st_d.flags[FLAG_Z] = (xorRes == BYTE_RST); // [RQ12]
              st_d.flags[FLAG_V] = 1'b0; // [RQ12]
              st_d.done = 1'b1; // [RQ19]
            end
            WMX_OP_TBL: begin
              st_d.resD = tblRes; // [RQ13]
              st_d.resDWe = 1'b1;
              st_d.flags[FLAG_N] = tblRes[WORD_W-1]; // [RQ17]
              st_d.flags[FLAG_Z] = (tblRes == WORD_RST); // [RQ17]
              st_d.flags[FLAG_C] = tblRound; // [RQ17]
              st_d.done = 1'b1;
            end
            default: begin
              st_d.done = 1'b1;
            end
          endcase
        end
      end
      WMX_WAIT: begin
        // Multiply result released after its free cycles
        if (st_q.waitCnt == 2'h1) begin
          st_d.resDWe = 1'b1;
          st_d.resYWe = 1'b1;
          st_d.done = 1'b1;
          st_d.busy = 1'b0;
          st_d.state = WMX_IDLE;
        end
        st_d.waitCnt = st_q.waitCnt - 2'h1;
      end
      default: st_d.state = WMX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '{state: WMX_IDLE, waitCnt: 2'h0, busy: 1'b0, done: 1'b0, resD: WORD_RST,
        resDWe: 1'b0, resY: WORD_RST, resYWe: 1'b0, resA: BYTE_RST,
        resAWe: 1'b0, resB: BYTE_RST, resBWe: 1'b0, memWrData: WORD_RST,
        memWe: 1'b0, flags: FLAGS_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  always_comb begin
    done = st_q.done;
    busy = st_q.busy;
    resD = st_q.resD;
    resDWe = st_q.resDWe;
    resY = st_q.resY;
    resYWe = st_q.resYWe;
    resA = st_q.resA;
    resAWe = st_q.resAWe;
    resB = st_q.resB;
    resBWe = st_q.resBWe;
    memWrData = st_q.memWrData;
    memWe = st_q.memWe;
    flagsOut = st_q.flags;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_mulReq;
    opStart && !busy && (opSel == WMX_OP_MUL_U || opSel == WMX_OP_MUL_S);
  endsequence

  sequence s_mulSlow;
    opStart && !busy && opSel == WMX_OP_MUL_S && newerCore && nextIsPrefixed;
  endsequence

  sequence s_mulFast;
    opStart && !busy && (opSel == WMX_OP_MUL_U
      || (opSel == WMX_OP_MUL_S && !(newerCore && nextIsPrefixed)));
  endsequence

  a_min_store: assert property (@(posedge core_clk) disable iff (rst) // [RQ1]
    (opStart && !busy && opSel == WMX_OP_MIN_TO_MEM) |=>
      memWe && memWrData == ($past(accD) < $past(memWord) ? $past(accD) : $past(memWord)))
    else $error("store-minimum wrote wrong value");

  a_min_carry: assert property (@(posedge core_clk) disable iff (rst) // [RQ4]
    (opStart && !busy && opSel == WMX_OP_MIN_TO_MEM) |=>
      flagsOut[FLAG_C] == ($past(memWord) > $past(accD)))
    else $error("store-minimum carry wrong");

  a_min_zero: assert property (@(posedge core_clk) disable iff (rst) // [RQ2]
    (opStart && !busy && opSel == WMX_OP_MIN_TO_MEM) |=>
      flagsOut[FLAG_Z] == ($past(accD) == $past(memWord)))
    else $error("store-minimum zero wrong");

  a_mul_fast: assert property (@(posedge core_clk) disable iff (rst) // [RQ5]
    s_mulFast |=> busy ##1 (done && resYWe && resDWe))
    else $error("multiply result timing wrong");

  a_mul_flags: assert property (@(posedge core_clk) disable iff (rst) // [RQ8]
    s_mulReq |=> flagsOut[FLAG_C] == resD[15] && flagsOut[FLAG_N] == resY[15]
      && flagsOut[FLAG_Z] == ({resY, resD} == 32'h00000000))
    else $error("multiply flags wrong");

  a_muls_slow: assert property (@(posedge core_clk) disable iff (rst) // [RQ9]
    s_mulSlow |=> busy [*2] ##1 (done && resDWe))
    else $error("signed multiply extra cycle missing");

  a_mul_keepv: assert property (@(posedge core_clk) disable iff (rst) // [RQ7]
    s_mulReq |=> flagsOut[FLAG_V] == $past(flagsIn[FLAG_V]))
    else $error("multiply altered overflow");

  a_xor_flags: assert property (@(posedge core_clk) disable iff (rst) // [RQ12]
    (opStart && !busy && (opSel == WMX_OP_XOR_A || opSel == WMX_OP_XOR_B)) |=>
      !flagsOut[FLAG_V] && flagsOut[FLAG_C] == $past(flagsIn[FLAG_C]))
    else $error("xor flags wrong");

  a_xor_b: assert property (@(posedge core_clk) disable iff (rst) // [RQ11]
    (opStart && !busy && opSel == WMX_OP_XOR_B) |=>
      resBWe && !resAWe && resB == ($past(accD[7:0]) ^ $past(memByte)))
    else $error("xor into second accumulator wrong");

  a_xor_a: assert property (@(posedge core_clk) disable iff (rst) // [RQ10]
    (opStart && !busy && opSel == WMX_OP_XOR_A) |=>
      resAWe && !resBWe && resA == ($past(accD[15:8]) ^ $past(memByte)))
    else $error("xor into first accumulator wrong");

  a_keep_upper: assert property (@(posedge core_clk) disable iff (rst) // [RQ18]
    (opStart && !busy) |=> flagsOut[7:4] == $past(flagsIn[7:4]))
    else $error("unlisted flags changed");

  a_tbl_zero: assert property (@(posedge core_clk) disable iff (rst) // [RQ17]
    (opStart && !busy && opSel == WMX_OP_TBL) |=>
      resDWe && flagsOut[FLAG_Z] == (resD == 16'h0000) && flagsOut[FLAG_N] == resD[15])
    else $error("interpolate flags wrong");
endmodule // wmx_datapath

/* verification/wmx_mem_model.sv */
`timescale 1ns/1ns
// Operand memory behind the fetch path, one word per address
module wmx_mem_model (
  // Clock
  input wire logic core_clk,
  // Word address of the operand
  input wire logic [3:0] memAddr,
  // Write back from the datapath
  input wire logic memWe,
  input wire logic [15:0] memWrData,
  // Fetched operands
  output logic [15:0] memWord,
  output logic [15:0] memWordNext,
  output logic [7:0] memByte
);
  logic [15:0] mem [16];

  // Plain pointer fetch of an entry and the one after it
  assign memWord = mem[memAddr];
  assign memWordNext = mem[memAddr + 4'h1];
  assign memByte = memWord[15:8];

  // Write back lands on the pointed word
  always @(posedge core_clk) begin
    if (memWe) begin
      mem[memAddr] <= memWrData;
    end
  end
endmodule // wmx_mem_model

/* verification/wmx_datapath_tb.sv */
`timescale 1ns/1ns
module wmx_datapath_tb;
  import wmx_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic opStart = 1'b0;
  wmx_op_e opSel = WMX_OP_MIN_TO_MEM;
  logic newerCore = 1'b0;
  logic nextIsPrefixed = 1'b0;
  logic [15:0] accD = 16'h0000;
  logic [15:0] idxY = 16'h0000;
  logic [7:0] flagsIn = 8'h00;
  logic [3:0] memAddr = 4'h0;
  logic [15:0] memWord, memWordNext, memWrData, resD, resY, eD, eY, eM;
  logic [7:0] memByte, resA, resB, flagsOut, eA, eB, eF;
  logic done, busy, resDWe, resYWe, resAWe, resBWe, memWe;
  logic [4:0] eMask;
  int lat;
  int err_total = 0;
  int checked = 0;

  // Free running clock
  always #5 core_clk = ~core_clk;

  wmx_datapath i_wmx_datapath (.core_clk(core_clk), .rst(rst), .opStart(opStart),
    .opSel(opSel), .newerCore(newerCore), .nextIsPrefixed(nextIsPrefixed), .accD(accD),
    .idxY(idxY), .flagsIn(flagsIn), .memWord(memWord), .memWordNext(memWordNext),
    .memByte(memByte), .done(done), .busy(busy), .resD(resD), .resDWe(resDWe),
    .resY(resY), .resYWe(resYWe), .resA(resA), .resAWe(resAWe), .resB(resB),
    .resBWe(resBWe), .memWrData(memWrData), .memWe(memWe), .flagsOut(flagsOut));

  wmx_mem_model i_wmx_mem_model (.core_clk(core_clk), .memAddr(memAddr), .memWe(memWe),
    .memWrData(memWrData), .memWord(memWord), .memWordNext(memWordNext),
    .memByte(memByte));

  // ----------------------------------------
  // Compare and verdict
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %0h, expected %0h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Reference model, mask order D Y A B M
  // ----------------------------------------
  task automatic model(input wmx_op_e op);
    int d, m, r, p;
    d = accD;
    m = memWord;
    eF = flagsIn;
    lat = 1;
    case (op)
      WMX_OP_MIN_TO_MEM: begin
        r = (d - m) & 32'hFFFF;
        eM = (d < m) ? accD : memWord;
        eMask = 5'h01;
        eF[FLAG_N] = r[15];
        eF[FLAG_Z] = (r == 0);
        eF[FLAG_V] = d[15] & ~m[15] & ~r[15] | ~d[15] & m[15] & r[15];
        eF[FLAG_C] = (m > d);
      end
      WMX_OP_MUL_U, WMX_OP_MUL_S: begin
        if (op == WMX_OP_MUL_U) begin
          p = d * idxY;
        end else begin
          p = $signed(accD) * $signed(idxY);
        end
        eY = p[31:16];
        eD = p[15:0];
        eMask = 5'h18;
        eF[FLAG_N] = p[31];
        eF[FLAG_Z] = (p == 0);
        eF[FLAG_C] = p[15];
        lat = (op == WMX_OP_MUL_S && newerCore && nextIsPrefixed) ? 3 : 2;
      end
      WMX_OP_XOR_A, WMX_OP_XOR_B: begin
        r = memByte ^ ((op == WMX_OP_XOR_A) ? accD[15:8] : accD[7:0]);
        eA = r[7:0];
        eB = r[7:0];
        eMask = (op == WMX_OP_XOR_A) ? 5'h04 : 5'h02;
        eF[FLAG_N] = r[7];
        eF[FLAG_Z] = (r == 0);
        eF[FLAG_V] = 1'b0;
      end
      default: begin
        r = memWordNext;
        p = accD[7:0] * (r - m);
        r = m + (p >>> 8);
        eD = r[15:0];
        eMask = 5'h10;
        eF[FLAG_N] = r[15];
        eF[FLAG_Z] = (r[15:0] == 0);
        eF[FLAG_C] = p[7];
      end
    endcase
  endtask

  // ----------------------------------------
  // One operation, optional request while busy
  // ----------------------------------------
  task automatic run_op(input wmx_op_e op, input logic [3:0] addr, input logic poke);
    int n;
    opSel = op;
    memAddr = addr;
    accD = addr[3] ? i_wmx_mem_model.mem[addr] : 16'($urandom);
    idxY = (addr[3:1] == 3'h7) ? 16'h0000 : 16'($urandom);
    flagsIn = 8'($urandom);
    newerCore = addr[2] | 1'($urandom);
    nextIsPrefixed = addr[2] | 1'($urandom);
    opStart = 1'b1;
    #1;
    model(op);
    @(negedge core_clk);
    n = 1;
    check(busy, lat > 1);
    opStart = poke & (lat > 1);
    opSel = WMX_OP_XOR_A;
    while (done !== 1'b1 && n < 6) begin
      @(negedge core_clk);
      opStart = 1'b0;
      n++;
    end
    check(n, lat);
    check({resDWe, resYWe, resAWe, resBWe, memWe}, eMask);
    check(flagsOut, eF);
    if (eMask[4]) check(resD, eD);
    if (eMask[3]) check(resY, eY);
    if (eMask[2]) check(resA, eA);
    if (eMask[1]) check(resB, eB);
    if (eMask[0]) check(memWrData, eM);
    @(negedge core_clk);
    if (eMask[0]) check(i_wmx_mem_model.mem[addr], eM);
  endtask

  // Main sequence, every operation ten times
  initial begin
    void'($urandom(32'h6E43));
    for (int i = 0; i < 16; i++) begin
      i_wmx_mem_model.mem[i] = 16'($urandom);
    end
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    check({done, busy, flagsOut}, {2'h0, FLAGS_RST});
    for (int k = 0; k < 60; k++) begin
      run_op(wmx_op_e'(k % 6), k[3:0], k % 5 == 1);
    end
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule // wmx_datapath_tb
